/* File: gpmd_port.sv */
// Purpose: Five 8-bit GPIO ports with masked pattern match detect
// Assumes: Register port is a byte SFR bus, one access per cycle
// Notes:   Read data appears one cycle after the read strobe
//
// Summary of operation
// - Written byte latched and driven until rewritten
// - Normal read returns present pin levels
// - Read-modify-write reads the latch, not pins
// - Ports 0-3 byte and bit, port 4 byte
// - Masked pins differing from masked value raise match
// - Match interrupt only when enable bit set
// - Match event wakes the suspended oscillator
// - Any wake event resumes suspended oscillator
`include "gpmd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gpmd_port
(
    input  wire logic       sys_clk,         // System clock, 100 MHz
    input  wire logic       rst_b,           // Async reset, active low
    input  wire logic [7:0] sfr_addr,        // Byte register address
    input  wire logic       sfr_wr,          // Byte write strobe
    input  wire logic       sfr_rd,          // Byte read strobe
    input  wire logic [7:0] sfr_wdata,       // Byte write data
    output logic      [7:0] sfr_rdata,       // Byte read data
    input  wire logic [7:0] sfr_bit_addr,    // Bit address
    input  wire logic       sfr_bit_wr,      // Bit write strobe
    input  wire logic       sfr_bit_rd,      // Bit read strobe
    input  wire logic       sfr_bit_wdata,   // Bit write value
    output logic            sfr_bit_rdata,   // Bit read data
    input  wire logic       sfr_rmw,         // Read is read-modify-write
    input  wire logic [7:0] port0_pin_in,    // Port 0 pin levels
    input  wire logic [7:0] port1_pin_in,    // Port 1 pin levels
    input  wire logic [7:0] port2_pin_in,    // Port 2 pin levels
    input  wire logic [7:0] port3_pin_in,    // Port 3 pin levels
    input  wire logic [7:0] port4_pin_in,    // Port 4 pin levels
    output logic      [7:0] port0_pin_out,   // Port 0 drive value
    output logic      [7:0] port1_pin_out,   // Port 1 drive value
    output logic      [7:0] port2_pin_out,   // Port 2 drive value
    output logic      [7:0] port3_pin_out,   // Port 3 drive value
    output logic      [7:0] port4_pin_out,   // Port 4 drive value
    output logic      [7:0] port0_pin_oe,    // Port 0 drive enable
    output logic      [7:0] port1_pin_oe,    // Port 1 drive enable
    output logic      [7:0] port2_pin_oe,    // Port 2 drive enable
    output logic      [7:0] port3_pin_oe,    // Port 3 drive enable
    output logic      [7:0] port4_pin_oe,    // Port 4 drive enable
    input  wire logic       osc_suspended,   // Oscillator in suspend
    input  wire logic       other_wake_in,   // Other wake sources
    output logic            osc_wake,        // Resume the oscillator
    output logic            match_irq        // Port match interrupt
);

    ////////////////////////////////////////////////////////////////////
    // Address tables

    localparam logic [7:0] LATCH_ADDR [5] = '{`GPMD_LATCH0_ADDR,
        `GPMD_LATCH1_ADDR, `GPMD_LATCH2_ADDR, `GPMD_LATCH3_ADDR,
        `GPMD_LATCH4_ADDR};
    localparam logic [7:0] DRIVE_ADDR [5] = '{`GPMD_DRIVE0_ADDR,
        `GPMD_DRIVE1_ADDR, `GPMD_DRIVE2_ADDR, `GPMD_DRIVE3_ADDR,
        `GPMD_DRIVE4_ADDR};
    localparam logic [7:0] INMODE_ADDR [5] = '{`GPMD_INMODE0_ADDR,
        `GPMD_INMODE1_ADDR, `GPMD_INMODE2_ADDR, `GPMD_INMODE3_ADDR,
        `GPMD_INMODE4_ADDR};
    localparam logic [7:0] MASK_ADDR [3] = '{`GPMD_MASK0_ADDR,
        `GPMD_MASK1_ADDR, `GPMD_MASK2_ADDR};
    localparam logic [7:0] VALUE_ADDR [3] = '{`GPMD_VALUE0_ADDR,
        `GPMD_VALUE1_ADDR, `GPMD_VALUE2_ADDR};

    ////////////////////////////////////////////////////////////////////
    // State

    gpmd_pkg::gpmd_state_t st_reg;            // Registered state
    gpmd_pkg::gpmd_state_t st_next;           // Next state
    logic [39:0]           pin_lvl;           // Pin levels, analog gated
    logic                  mismatch;          // Any masked mismatch
    logic [2:0]            bit_port;          // Port of bit address
    logic                  bit_ok;            // Bit address is a port bit

    // Bit address: upper nibble picks port, bit 3 must be clear
    assign bit_port = sfr_bit_addr[6:4];
    assign bit_ok   = sfr_bit_addr[7] && !sfr_bit_addr[3] &&
                      (bit_port < 3'(`GPMD_NUM_BIT_PORTS));

    // Analog inputs read as zero; only stage two is looked at
    assign pin_lvl  = st_reg.sync2 & st_reg.inmode;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        st_next = st_reg;
        mismatch = 1'b0;
        // Two-flop synchroniser on every pin
        st_next.sync1 = {port4_pin_in, port3_pin_in, port2_pin_in,
                         port1_pin_in, port0_pin_in};
        st_next.sync2 = st_reg.sync1;

        // Byte reads: unmapped addresses answer zero
        if (sfr_rd)
        begin
            st_next.rdata = `GPMD_UNMAPPED_READ;
            for (int i = 0; i < `GPMD_NUM_PORTS; i++)
            begin
                if (sfr_addr == LATCH_ADDR[i])
                begin
                    // Plain read sees pins, read-modify-write the latch
                    st_next.rdata = sfr_rmw ? st_reg.latch[i]
                                            : pin_lvl[i*8 +: 8];
                end
                if (sfr_addr == DRIVE_ADDR[i])
                    st_next.rdata = st_reg.drive[i];
                if (sfr_addr == INMODE_ADDR[i])
                    st_next.rdata = st_reg.inmode[i];
            end
            for (int i = 0; i < `GPMD_NUM_CMP_PORTS; i++)
            begin
                if (sfr_addr == MASK_ADDR[i])
                    st_next.rdata = st_reg.mask[i];
                if (sfr_addr == VALUE_ADDR[i])
                    st_next.rdata = st_reg.value[i];
            end
            if (sfr_addr == `GPMD_IRQ_EN_TWO_ADDR)
                st_next.rdata = st_reg.irq_en_two;
        end

        // Byte writes
        if (sfr_wr)
        begin
            for (int i = 0; i < `GPMD_NUM_PORTS; i++)
            begin
                if (sfr_addr == LATCH_ADDR[i])
                    st_next.latch[i] = sfr_wdata;
                if (sfr_addr == DRIVE_ADDR[i])
                    st_next.drive[i] = sfr_wdata;
                if (sfr_addr == INMODE_ADDR[i])
                    st_next.inmode[i] = sfr_wdata;
            end
            for (int i = 0; i < `GPMD_NUM_CMP_PORTS; i++)
            begin
                if (sfr_addr == MASK_ADDR[i])
                    st_next.mask[i] = sfr_wdata;
                if (sfr_addr == VALUE_ADDR[i])
                    st_next.value[i] = sfr_wdata;
            end
            if (sfr_addr == `GPMD_IRQ_EN_TWO_ADDR)
                st_next.irq_en_two = sfr_wdata;
        end

        // Bit reads; a bad bit address answers zero
        if (sfr_bit_rd)
        begin
            st_next.bit_rdata = 1'b0;
            if (bit_ok)
            begin
                st_next.bit_rdata = sfr_rmw ?
                    st_reg.latch[bit_port][sfr_bit_addr[2:0]] :
                    pin_lvl[{bit_port, sfr_bit_addr[2:0]}];
            end
        end

        // Bit writes touch only the addressed latch bit
        if (sfr_bit_wr && bit_ok)
            st_next.latch[bit_port][sfr_bit_addr[2:0]] =
                sfr_bit_wdata;

        // Masked compare, evaluated every cycle, crossbar ignored
        for (int i = 0; i < `GPMD_NUM_CMP_PORTS; i++)
        begin
            if ((st_reg.sync2[i] & st_reg.mask[i]) !=
                (st_reg.value[i] & st_reg.mask[i]))
                mismatch = 1'b1;
        end
        st_next.match = mismatch;

        // Wake holds only while the oscillator is suspended
        st_next.wake = osc_suspended &&
                       (st_reg.match || other_wake_in);
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg            <= '0;
            st_reg.latch      <= {5{`GPMD_LATCH_RESET}};
            st_reg.drive      <= {5{`GPMD_DRIVE_RESET}};
            st_reg.inmode     <= {5{`GPMD_INMODE_RESET}};
            st_reg.mask       <= {3{`GPMD_MASK_RESET}};
            st_reg.value      <= {3{`GPMD_VALUE_RESET}};
            st_reg.irq_en_two <= `GPMD_IRQ_EN_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Pins: zero always drives low, one drives only in push-pull
    assign port0_pin_out = st_reg.latch[0];
    assign port1_pin_out = st_reg.latch[1];
    assign port2_pin_out = st_reg.latch[2];
    assign port3_pin_out = st_reg.latch[3];
    assign port4_pin_out = st_reg.latch[4];
    assign port0_pin_oe  = ~st_reg.latch[0] | st_reg.drive[0];
    assign port1_pin_oe  = ~st_reg.latch[1] | st_reg.drive[1];
    assign port2_pin_oe  = ~st_reg.latch[2] | st_reg.drive[2];
    assign port3_pin_oe  = ~st_reg.latch[3] | st_reg.drive[3];
    assign port4_pin_oe  = ~st_reg.latch[4] | st_reg.drive[4];

    assign sfr_rdata     = st_reg.rdata;
    assign sfr_bit_rdata = st_reg.bit_rdata;
    assign osc_wake      = st_reg.wake;
    // Interrupt request gated by the pattern enable bit
    assign match_irq     = st_reg.match &&
        st_reg.irq_en_two[`GPMD_PATTERN_IRQ_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_p0_write;
        sfr_wr && sfr_addr == `GPMD_LATCH0_ADDR;
    endsequence
    sequence s_pins_steady;
        $stable(port0_pin_in) [*3];
    endsequence

    a_latch_drives_pin: assert property (s_p0_write |=>
        port0_pin_out == $past(sfr_wdata))
        else $error("Port 0 write not driven on pins");
    a_plain_read_pin: assert property (s_pins_steady ##0
        (sfr_rd && !sfr_rmw && sfr_addr == `GPMD_LATCH0_ADDR &&
         st_reg.inmode[0] == 8'hFF) |=> sfr_rdata == $past(port0_pin_in, 3))
        else $error("Plain read did not return pins");
    a_rmw_read_latch: assert property ((sfr_rd && sfr_rmw &&
        sfr_addr == `GPMD_LATCH1_ADDR) |=> sfr_rdata == $past(port1_pin_out))
        else $error("Read-modify-write did not return latch");
    // Port 2 bit write with no byte write in the same cycle: addressed bit takes the value, others hold
    a_bit_write_only: assert property ((sfr_bit_wr && !sfr_wr &&
        sfr_bit_addr[7:4] == 4'hA && !sfr_bit_addr[3]) |=>
        port2_pin_out[$past(sfr_bit_addr[2:0])] == $past(sfr_bit_wdata) &&
        ((port2_pin_out ^ $past(port2_pin_out)) &
         ~(8'h01 << $past(sfr_bit_addr[2:0]))) == 8'h00)
        else $error("Bit write to port 2 wrong");
    a_port4_byte_only: assert property ((!sfr_wr) |=>
        port4_pin_out == $past(port4_pin_out))
        else $error("Port 4 changed without byte write");
    a_match_from_pins: assert property (s_pins_steady ##0
        ($stable(st_reg.mask[0]) && $stable(st_reg.value[0]) &&
         ((port0_pin_in & st_reg.mask[0]) !=
          (st_reg.value[0] & st_reg.mask[0]))) |=> st_reg.match)
        else $error("Masked mismatch did not raise match");
    a_irq_gated: assert property (match_irq |->
        st_reg.match && st_reg.irq_en_two[`GPMD_PATTERN_IRQ_ENABLE_BIT])
        else $error("Interrupt without enable");
    a_wake_on_match: assert property ((osc_suspended &&
        st_reg.match) |=> osc_wake)
        else $error("Match did not wake oscillator");
    a_wake_other: assert property ((osc_suspended &&
        other_wake_in) |=> osc_wake)
        else $error("Wake event did not wake oscillator");
    a_open_drain_high: assert property ((port0_pin_out[0] &&
        !st_reg.drive[0][0]) |-> !port0_pin_oe[0])
        else $error("Open-drain high bit is driven");
    a_sync_two_cycles: assert property ((s_pins_steady) |->
        st_reg.sync2[0] == port0_pin_in)
        else $error("Synchroniser not two cycles deep");

endmodule

`default_nettype wire

/* File: gpmd_params.svh */
// Purpose: Addresses, field positions, reset values for the GPIO block
// Assumes: Byte-wide special function register space
// Notes:   Included by the package and by the port module
`ifndef GPMD_PARAMS_SVH
`define GPMD_PARAMS_SVH

// Port output latches (ports 0..3 bit addressable, port 4 byte only)
`define GPMD_LATCH0_ADDR     8'h80
`define GPMD_LATCH1_ADDR     8'h90
`define GPMD_LATCH2_ADDR     8'hA0
`define GPMD_LATCH3_ADDR     8'hB0
`define GPMD_LATCH4_ADDR     8'hC7
// Output drive mode per port (1 = push-pull)
`define GPMD_DRIVE0_ADDR     8'hA4
`define GPMD_DRIVE1_ADDR     8'hA5
`define GPMD_DRIVE2_ADDR     8'hA6
`define GPMD_DRIVE3_ADDR     8'hA7
`define GPMD_DRIVE4_ADDR     8'hAE
// Input mode per port (0 = analog, reads zero)
`define GPMD_INMODE0_ADDR    8'hF1
`define GPMD_INMODE1_ADDR    8'hF2
`define GPMD_INMODE2_ADDR    8'hF3
`define GPMD_INMODE3_ADDR    8'hF4
`define GPMD_INMODE4_ADDR    8'hF5
// Compare masks and values for ports 0..2
`define GPMD_MASK0_ADDR      8'hC1
`define GPMD_MASK1_ADDR      8'hC2
`define GPMD_MASK2_ADDR      8'hC3
`define GPMD_VALUE0_ADDR     8'hD1
`define GPMD_VALUE1_ADDR     8'hD2
`define GPMD_VALUE2_ADDR     8'hD3
// Extended interrupt enable two
`define GPMD_IRQ_EN_TWO_ADDR 8'hE7
`define GPMD_PATTERN_IRQ_ENABLE_BIT 1

// Reset values
`define GPMD_LATCH_RESET     8'hFF
`define GPMD_DRIVE_RESET     8'h00
`define GPMD_INMODE_RESET    8'hFF
`define GPMD_MASK_RESET      8'h00
`define GPMD_VALUE_RESET     8'h00
`define GPMD_IRQ_EN_RESET    8'h00
`define GPMD_UNMAPPED_READ   8'h00

// Counts
`define GPMD_NUM_PORTS       5
`define GPMD_NUM_BIT_PORTS   4
`define GPMD_NUM_CMP_PORTS   3

`endif

/* File: gpmd_pkg.sv */
// Purpose: Types for the GPIO port with match detect
// Assumes: gpmd_params.svh supplies the constants
// Notes:   State of the port module is a single packed struct
`include "gpmd_params.svh"
`default_nettype none

package gpmd_pkg;

    typedef logic [7:0] gpmd_byte_t;                 // One port byte

    // Whole register state of the port module
    typedef struct packed {
        gpmd_byte_t [4:0] latch;                      // Output latches
        gpmd_byte_t [4:0] drive;                      // 1 = push-pull
        gpmd_byte_t [4:0] inmode;                     // 0 = analog input
        gpmd_byte_t [2:0] mask;                       // Compare masks
        gpmd_byte_t [2:0] value;                      // Compare values
        gpmd_byte_t       irq_en_two;                 // Extended enable two
        gpmd_byte_t [4:0] sync1;                      // Pin sync stage one
        gpmd_byte_t [4:0] sync2;                      // Pin sync stage two
        gpmd_byte_t       rdata;                      // Byte read data
        logic             bit_rdata;                  // Bit read data
        logic             match;                      // Match event level
        logic             wake;                       // Oscillator wake
    } gpmd_state_t;

endpackage

`default_nettype wire

/* File: gpmd_pin_model.sv */
// Purpose: Board side of one 8-bit port, merging drive with board levels
// Assumes: Board holds every released pin at ext_level
// Notes:   No delay; a released pin never keeps the port's last drive
`timescale 1ns/1ps
`default_nettype none

module gpmd_pin_model
(
    input  wire logic [7:0] pin_out,    // Value the port drives
    input  wire logic [7:0] pin_oe,     // 1 = port drives the pin
    input  wire logic [7:0] ext_level,  // Board level where released
    output logic      [7:0] pin_level   // Resolved wire level
);
    ////////////////////////////////////////////////////////////////////////
    // Per-bit resolve: board level shows only where the port lets go,
    // so a high-impedance one reads whatever the board holds
    always_comb
    begin
        pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
    end
endmodule
`default_nettype wire

/* File: tb_gpmd_port.sv */
// Purpose: Self-checking bench for the five-port GPIO with match detect
// Assumes: Pins held stable five cycles before any read or level check
// Notes:   Reference model keeps latches, modes and compare setup
`include "gpmd_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb_gpmd_port;
    logic       sys_clk = 1'b0;         // 100 MHz system clock
    logic       rst_b = 1'b0;           // Active low reset
    logic [7:0] sfr_addr = 8'h00;       // Byte address
    logic       sfr_wr = 1'b0;          // Byte write strobe
    logic       sfr_rd = 1'b0;          // Byte read strobe
    logic [7:0] sfr_wdata = 8'h00;      // Byte write data
    wire  [7:0] sfr_rdata;              // Byte read data
    logic [7:0] sfr_bit_addr = 8'h00;   // Bit address
    logic       sfr_bit_wr = 1'b0;      // Bit write strobe
    logic       sfr_bit_rd = 1'b0;      // Bit read strobe
    logic       sfr_bit_wdata = 1'b0;   // Bit write value
    wire        sfr_bit_rdata;          // Bit read data
    logic       sfr_rmw = 1'b0;         // Read-modify-write qualifier
    logic       osc_suspended = 1'b0;   // Oscillator suspended
    logic       other_wake_in = 1'b0;   // Other wake sources
    wire        osc_wake;               // Oscillator resume
    wire        match_irq;              // Match interrupt
    wire  [7:0] pout [5];               // Port drive values
    wire  [7:0] poe [5];                // Port drive enables
    wire  [7:0] pin [5];                // Resolved pin levels
    logic [7:0] ext [5];                // Board levels
    logic [7:0] m_latch [5];            // Model latches
    logic [7:0] m_drive [5];            // Model drive modes
    logic [7:0] m_inmode [5];           // Model input modes
    logic [7:0] m_mask [3];             // Model compare masks
    logic [7:0] m_value [3];            // Model compare values
    logic [7:0] m_irqen;                // Model irq enable two
    logic [15:0] rnd = 16'h4E9A;        // Random state
    int         error_cnt = 0;          // Mismatches
    int         samples_checked = 0;    // Comparisons made
    logic [7:0] a_lat [5] = '{`GPMD_LATCH0_ADDR, `GPMD_LATCH1_ADDR,
        `GPMD_LATCH2_ADDR, `GPMD_LATCH3_ADDR, `GPMD_LATCH4_ADDR};
    logic [7:0] a_drv [5] = '{`GPMD_DRIVE0_ADDR, `GPMD_DRIVE1_ADDR,
        `GPMD_DRIVE2_ADDR, `GPMD_DRIVE3_ADDR, `GPMD_DRIVE4_ADDR};
    logic [7:0] a_inm [5] = '{`GPMD_INMODE0_ADDR, `GPMD_INMODE1_ADDR,
        `GPMD_INMODE2_ADDR, `GPMD_INMODE3_ADDR, `GPMD_INMODE4_ADDR};
    logic [7:0] a_msk [3] = '{`GPMD_MASK0_ADDR, `GPMD_MASK1_ADDR,
        `GPMD_MASK2_ADDR};
    logic [7:0] a_val [3] = '{`GPMD_VALUE0_ADDR, `GPMD_VALUE1_ADDR,
        `GPMD_VALUE2_ADDR};

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and board models
    always #5 sys_clk = ~sys_clk;

    gpmd_port u_gpmd_port (.sys_clk(sys_clk), .rst_b(rst_b),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_rd(sfr_bit_rd), .sfr_bit_wdata(sfr_bit_wdata),
        .sfr_bit_rdata(sfr_bit_rdata), .sfr_rmw(sfr_rmw),
        .port0_pin_in(pin[0]), .port1_pin_in(pin[1]), .port2_pin_in(pin[2]),
        .port3_pin_in(pin[3]), .port4_pin_in(pin[4]),
        .port0_pin_out(pout[0]), .port1_pin_out(pout[1]),
        .port2_pin_out(pout[2]), .port3_pin_out(pout[3]),
        .port4_pin_out(pout[4]), .port0_pin_oe(poe[0]),
        .port1_pin_oe(poe[1]), .port2_pin_oe(poe[2]), .port3_pin_oe(poe[3]),
        .port4_pin_oe(poe[4]), .osc_suspended(osc_suspended),
        .other_wake_in(other_wake_in), .osc_wake(osc_wake),
        .match_irq(match_irq));

    for (genvar g = 0; g < 5; g++)
    begin : g_pins
        gpmd_pin_model u_gpmd_pin_model (.pin_out(pout[g]), .pin_oe(poe[g]),
            .ext_level(ext[g]), .pin_level(pin[g]));
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference model helpers
    function automatic logic [7:0] exp_oe(input int p);
        return ~m_latch[p] | m_drive[p];
    endfunction

    function automatic logic [7:0] exp_pin(input int p);
        return (m_latch[p] & exp_oe(p)) | (ext[p] & ~exp_oe(p));
    endfunction

    // Sixteen-bit Fibonacci shift register, low byte used
    function automatic logic [7:0] rand8();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus tasks: strobe raised after an edge, dropped after the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic m,
                      output logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rmw  <= m;
        sfr_rd   <= 1'b1;
        @(posedge sys_clk);
        sfr_rd   <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    task automatic bit_acc(input logic [7:0] a, input logic w, input logic v,
                           input logic m, output logic d);
        @(posedge sys_clk);
        sfr_bit_addr  <= a;
        sfr_bit_wdata <= v;
        sfr_rmw       <= m;
        sfr_bit_wr    <= w;
        sfr_bit_rd    <= ~w;
        @(posedge sys_clk);
        sfr_bit_wr    <= 1'b0;
        sfr_bit_rd    <= 1'b0;
        #1 d = sfr_bit_rdata;
    endtask

    // Outputs versus model once pins and sync stages have settled
    task automatic check_levels();
        logic mexp;
        logic wexp;
        mexp = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        for (int p = 0; p < 5; p++)
        begin
            `CHK("pin_out", m_latch[p], pout[p])
            `CHK("pin_oe", exp_oe(p), poe[p])
        end
        for (int p = 0; p < 3; p++)
            mexp |= ((exp_pin(p) & m_mask[p]) != (m_value[p] & m_mask[p]));
        `CHK("match_irq", mexp & m_irqen[1], match_irq)
        wexp = osc_suspended & (mexp | other_wake_in);
        `CHK("osc_wake", wexp, osc_wake)
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: whole run is about a thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] d;
        logic       b;
        logic [2:0] bi;
        for (int p = 0; p < 5; p++)
        begin
            ext[p] = 8'h00;
            m_latch[p] = `GPMD_LATCH_RESET;
            m_drive[p] = `GPMD_DRIVE_RESET;
            m_inmode[p] = `GPMD_INMODE_RESET;
        end
        for (int p = 0; p < 3; p++)
        begin
            m_mask[p] = `GPMD_MASK_RESET;
            m_value[p] = `GPMD_VALUE_RESET;
        end
        m_irqen = `GPMD_IRQ_EN_RESET;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        check_levels();
        for (int r = 0; r < 8; r++)
        begin
            // Fresh random setup of every register and board level, except input modes held at FF in rounds 0 and 1
            for (int p = 0; p < 5; p++)
            begin
                m_latch[p] = rand8();
                m_drive[p] = rand8();
                m_inmode[p] = (r < 2) ? 8'hFF : rand8();
                ext[p] <= rand8();
                wr(a_lat[p], m_latch[p]);
                wr(a_drv[p], m_drive[p]);
                wr(a_inm[p], m_inmode[p]);
            end
            for (int p = 0; p < 3; p++)
            begin
                // Odd rounds mask only a few bits, so no-match happens too
                m_mask[p] = rand8() & ((r % 2) ? 8'h03 : 8'hFF);
                m_value[p] = rand8();
                wr(a_msk[p], m_mask[p]);
                wr(a_val[p], m_value[p]);
            end
            m_irqen = rand8();
            wr(`GPMD_IRQ_EN_TWO_ADDR, m_irqen);
            osc_suspended <= rnd[8];
            other_wake_in <= rnd[9] & rnd[11];
            check_levels();
            // Byte reads: pins normally, latch under read-modify-write
            for (int p = 0; p < 5; p++)
            begin
                rd(a_lat[p], 1'b0, d);
                `CHK("byte pins", exp_pin(p) & m_inmode[p], d)
                rd(a_lat[p], 1'b1, d);
                `CHK("byte latch", m_latch[p], d)
            end
            // Bit write, then bit reads, on every bit-addressable port
            for (int p = 0; p < 4; p++)
            begin
                // Fresh random bit and value for every port
                d = rand8();
                bi = d[2:0];
                b = d[5];
                m_latch[p][bi] = b;
                bit_acc(8'h80 + 8'(p * 16) + 8'(bi), 1'b1, b, 1'b0, b);
                check_levels();
                bit_acc(8'h80 + 8'(p * 16) + 8'(bi), 1'b0, 1'b0, 1'b0, b);
                d = exp_pin(p) & m_inmode[p];
                `CHK("bit pin", d[bi], b)
                bit_acc(8'h80 + 8'(p * 16) + 8'(bi), 1'b0, 1'b0, 1'b1, b);
                `CHK("bit latch", m_latch[p][bi], b)
            end
            // Port 4 has no bit access: write ignored, read gives zero
            bit_acc(8'hC0 + 8'(rnd[2:0]), 1'b1, ~m_latch[4][0], 1'b0, b);
            bit_acc(8'hC0, 1'b0, 1'b0, 1'b1, b);
            `CHK("port4 bit read", 1'b0, b)
            rd(8'h81, 1'b0, d);
            `CHK("unmapped read", `GPMD_UNMAPPED_READ, d)
            // Even rounds: compare values set to the pins, match clears
            if (r % 2 == 0)
                for (int p = 0; p < 3; p++)
                begin
                    m_value[p] = exp_pin(p);
                    wr(a_val[p], m_value[p]);
                end
            check_levels();
        end
        conclude();
    end
endmodule
`default_nettype wire
